/* logic/itd_pkg.sv */
// Behaviour
// RULE_01 - Program must begin with inline-header descriptor
// RULE_02 - Inline-header byte count is eight
// RULE_03 - Header taken from descriptor's lower area; code reads it from byte 10h, the upper half of the inline descriptor
// RULE_04 - First final zero-count descriptor skips cycle
// RULE_05 - Opcode 0h continues, 1h finishes packet
// RULE_06 - Variant 0h buffer, 2h inline, 6h store
// RULE_07 - Writeback flag gates status store on finals
// RULE_08 - Interrupt select 11b raises transmit event
// RULE_09 - Buffer descriptors move requested bytes out
// RULE_10 - Store writes zero-padded halfword to pointer
// RULE_11 - Next-block pointer used only when count nonzero
// RULE_12 - Bus reset or lost cycle resumes at recovery
// RULE_13 - Next-block count zero ends, else block size
// RULE_14 - Count one only before zero-count final
// RULE_15 - Completion status mirrors control register layout
// RULE_16 - Completion time from cycle and seconds bits
// RULE_17 - Only five descriptor types valid, others rejected
// RULE_18 - Software checks active, loads pointer, sets run
// RULE_19 - Loaded count is descriptors plus one
// RULE_20 - Interrupt on select 11b/01b with mask set
// RULE_21 - Branch control field always all ones
// RULE_22 - After final, follow next block or stop
package itd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PROG = 8'h04;
  localparam logic [7:0] OFF_EVENT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;

  // Control register layout, also the completion status layout
  localparam int CTL_RUN_BIT = 15;
  localparam int CTL_DEAD_BIT = 11;
  localparam int CTL_ACTIVE_BIT = 10;
  localparam logic [4:0] EVT_NONE = 5'h00;
  localparam logic [4:0] EVT_DONE = 5'h11;
  localparam logic [4:0] EVT_SKIPPED = 5'h0D;
  localparam logic [4:0] EVT_BAD_DESC = 5'h0E;
  localparam logic [4:0] EVT_RECOVER = 5'h0F;

  // Descriptor word 0 fields
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 28;
  localparam int WB_BIT = 27;
  localparam int VAR_MSB = 26;
  localparam int VAR_LSB = 24;
  localparam int ISEL_MSB = 21;
  localparam int ISEL_LSB = 20;
  localparam int REQ_MSB = 15;
  localparam int REQ_LSB = 0;
  localparam logic [3:0] OPC_CONT = 4'h0;
  localparam logic [3:0] OPC_FINAL = 4'h1;
  localparam logic [2:0] VAR_BUF = 3'h0;
  localparam logic [2:0] VAR_INLINE = 3'h2;
  localparam logic [2:0] VAR_STORE = 3'h6;
  localparam logic [1:0] ISEL_EVT = 2'h3;
  localparam logic [1:0] ISEL_ALT = 2'h1;

  // Descriptor geometry
  localparam logic [1:0] DESC_LAST_IDX = 2'h3;
  localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
  localparam logic [31:0] INLINE_BYTES = 32'h0000_0020;
  localparam logic [31:0] HDR_OFS = 32'h0000_0010;
  localparam logic [31:0] WB_OFS = 32'h0000_000C;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [15:0] HDR_BYTES = 16'h0008;
  localparam logic [15:0] WORD_CNT = 16'h0004;
  localparam logic [3:0] INLINE_SLOTS = 4'h2;
  localparam logic [3:0] PLAIN_SLOTS = 4'h1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_FETCH = 4'b0001,
    ST_DECODE = 4'b0010,
    ST_READ = 4'b0011,
    ST_PUSH = 4'b0100,
    ST_STORE = 4'b0101,
    ST_FIN = 4'b0110,
    ST_WB = 4'b0111,
    ST_LINK = 4'b1000
  } itd_state_t;

endpackage

/* logic/itd_engine.sv */
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module itd_engine
  import itd_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic MEM_REQ,
  output logic MEM_WRITE,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  output logic TXB_VALID,
  output logic [31:0] TXB_DATA,
  output logic TXB_LAST,
  input wire logic TXB_READY,
  input wire logic BUS_RESET,
  input wire logic CYCLE_LOST,
  input wire logic [12:0] CYCLE_NUMBER,
  input wire logic [6:0] SECONDS_COUNT,
  output logic IRQ
);

  typedef struct packed {
    itd_state_t state;
    logic ahb_wr;
    logic [7:0] ahb_ofs;
    logic [31:0] rdata;
    logic run;
    logic active;
    logic dead;
    logic [4:0] evcode;
    logic evt;
    logic mask;
    logic [27:0] prog_addr;
    logic [3:0] prog_cnt;
    logic [31:0] cur;
    logic [3:0] remain;
    logic first;
    logic [3:0][31:0] desc;
    logic [1:0] widx;
    logic [31:0] dptr;
    logic [15:0] dleft;
    logic [27:0] recov;
    logic [3:0] recov_cnt;
    logic recov_ok;
    logic mreq;
    logic mwe;
    logic [31:0] maddr;
    logic [31:0] mwdata;
    logic txv;
    logic txl;
    logic [31:0] txd;
    logic [2:0] brs;
    logic [2:0] cls;
    logic brf;
    logic clf;
  } itd_st_t;

  itd_st_t r;
  itd_st_t n;

  function automatic logic [31:0] ctrl_word(input itd_st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTL_RUN_BIT] = s.run;
    w[CTL_DEAD_BIT] = s.dead;
    w[CTL_ACTIVE_BIT] = s.active;
    w[4:0] = s.evcode;
    return w;
  endfunction

  logic [3:0] opc;
  logic [2:0] vsel;
  logic [15:0] req;
  logic [1:0] isel;
  logic [3:0] zcnt;
  logic is_inline;
  logic is_final;
  logic desc_ok;
  logic restart_ev;
  logic [3:0] slots;
  logic [31:0] ctl_w;

  always_comb begin
    opc = r.desc[0][OPC_MSB:OPC_LSB];
    vsel = r.desc[0][VAR_MSB:VAR_LSB];
    req = r.desc[0][REQ_MSB:REQ_LSB];
    isel = r.desc[0][ISEL_MSB:ISEL_LSB];
    zcnt = r.desc[2][3:0];
    ctl_w = ctrl_word(r);
    is_inline = (vsel == VAR_INLINE);
    is_final = (opc == OPC_FINAL);
    // RULE_17 five accepted types
    desc_ok = ((vsel == VAR_BUF || vsel == VAR_INLINE) && (opc == OPC_CONT || opc == OPC_FINAL))
      || (vsel == VAR_STORE && opc == OPC_CONT);
    slots = is_inline ? INLINE_SLOTS : PLAIN_SLOTS;
    // RULE_12 filtered restart events
    restart_ev = ((r.brs[1] == r.brs[2]) && r.brs[2] && !r.brf)
      || ((r.cls[1] == r.cls[2]) && r.cls[2] && !r.clf);

    n = r;

    // Pin synchronisers, change taken when stages two and three agree
    n.brs = {r.brs[1:0], BUS_RESET};
    n.cls = {r.cls[1:0], CYCLE_LOST};
    if (r.brs[1] == r.brs[2]) begin
      n.brf = r.brs[2];
    end
    if (r.cls[1] == r.cls[2]) begin
      n.clf = r.cls[2];
    end

    // Register writes in the data phase
    n.ahb_wr = 1'b0;
    if (r.ahb_wr) begin
      case (r.ahb_ofs)
        OFF_CTRL: begin
          n.run = HWDATA[CTL_RUN_BIT];
          n.dead = 1'b0;
        end
        OFF_PROG: begin
          n.prog_addr = HWDATA[31:4];
          n.prog_cnt = HWDATA[3:0];
        end
        OFF_EVENT: begin
          if (HWDATA[0]) begin
            n.evt = 1'b0;
          end
        end
        OFF_MASK: begin
          n.mask = HWDATA[0];
        end
        default: begin
        end
      endcase
    end

    // Transmit buffer handshake
    if (r.txv && TXB_READY) begin
      n.txv = 1'b0;
      n.txl = 1'b0;
    end

    case (r.state)
      ST_IDLE: begin
        n.active = 1'b0;
        n.mreq = 1'b0;
        n.mwe = 1'b0;
        // RULE_19 count loaded from pointer
        if (r.run && !r.dead && r.prog_cnt != 4'h0) begin
          n.active = 1'b1;
          n.cur = {r.prog_addr, 4'h0};
          n.remain = r.prog_cnt;
          n.first = 1'b1;
          n.widx = 2'h0;
          n.recov_ok = 1'b0;
          n.evcode = EVT_NONE;
          n.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (!r.mreq) begin
          n.mreq = 1'b1;
          n.mwe = 1'b0;
          n.maddr = r.cur + {28'h000_0000, r.widx, 2'h0};
        end else if (MEM_ACK) begin
          n.mreq = 1'b0;
          n.desc[r.widx] = MEM_RDATA;
          n.widx = r.widx + 2'h1;
          if (r.widx == DESC_LAST_IDX) begin
            n.state = ST_DECODE;
          end
        end
      end
      ST_DECODE: begin
        n.first = 1'b0;
        if (!desc_ok) begin
          // RULE_17 invalid type stops context
          n.dead = 1'b1;
          n.evcode = EVT_BAD_DESC;
          n.state = ST_IDLE;
        end else begin
          // RULE_12 recovery pointer latched
          if (r.first && (is_inline || (is_final && vsel == VAR_BUF && req == 16'h0000))) begin
            n.recov = r.desc[2][31:4];
            n.recov_cnt = r.desc[2][3:0];
            n.recov_ok = 1'b1;
          end
          // RULE_06 variant selects handling
          case (vsel)
            VAR_INLINE: begin
              // RULE_03 header from descriptor body
              n.dptr = r.cur + HDR_OFS;
              n.dleft = HDR_BYTES;
              n.state = ST_READ;
            end
            VAR_STORE: begin
              n.state = ST_STORE;
            end
            default: begin
              // RULE_09 payload from buffer pointer
              n.dptr = r.desc[1];
              n.dleft = req;
              // RULE_04 zero count sends nothing
              n.state = (req == 16'h0000) ? ST_FIN : ST_READ;
            end
          endcase
        end
      end
      ST_READ: begin
        if (!r.mreq) begin
          n.mreq = 1'b1;
          n.mwe = 1'b0;
          n.maddr = r.dptr;
        end else if (MEM_ACK) begin
          n.mreq = 1'b0;
          n.txd = MEM_RDATA;
          n.txv = 1'b1;
          // RULE_05 final marks packet end
          n.txl = is_final && (r.dleft <= WORD_CNT);
          n.dptr = r.dptr + WORD_BYTES;
          n.dleft = (r.dleft > WORD_CNT) ? r.dleft - WORD_CNT : 16'h0000;
          n.state = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (r.txv && TXB_READY) begin
          n.state = (r.dleft == 16'h0000) ? ST_FIN : ST_READ;
        end
      end
      ST_STORE: begin
        // RULE_10 zero-padded halfword write
        if (!r.mreq) begin
          n.mreq = 1'b1;
          n.mwe = 1'b1;
          n.maddr = r.desc[1];
          n.mwdata = {16'h0000, r.desc[0][15:0]};
        end else if (MEM_ACK) begin
          n.mreq = 1'b0;
          n.mwe = 1'b0;
          n.state = ST_FIN;
        end
      end
      ST_FIN: begin
        n.widx = 2'h0;
        if (is_final) begin
          n.evcode = (req == 16'h0000 && vsel == VAR_BUF) ? EVT_SKIPPED : EVT_DONE;
          // RULE_07 writeback only when flagged
          n.state = r.desc[0][WB_BIT] ? ST_WB : ST_LINK;
        end else begin
          n.cur = r.cur + (is_inline ? INLINE_BYTES : DESC_BYTES);
          n.remain = (r.remain > slots) ? r.remain - slots : 4'h0;
          if (n.remain == 4'h0) begin
            n.run = 1'b0;
            n.state = ST_IDLE;
          end else begin
            n.state = ST_FETCH;
          end
        end
      end
      ST_WB: begin
        if (!r.mreq) begin
          n.mreq = 1'b1;
          n.mwe = 1'b1;
          n.maddr = r.cur + WB_OFS;
          // RULE_15 status in control layout
          // RULE_16 seconds low bits with cycle
          n.mwdata = {ctl_w[15:0], SECONDS_COUNT[2:0], CYCLE_NUMBER};
        end else if (MEM_ACK) begin
          n.mreq = 1'b0;
          n.mwe = 1'b0;
          n.state = ST_LINK;
        end
      end
      ST_LINK: begin
        // RULE_08 event on select code
        // RULE_20 select 11b or 01b
        if (isel == ISEL_EVT || isel == ISEL_ALT) begin
          n.evt = 1'b1;
        end
        // RULE_22 follow block or stop
        // RULE_13 zero count ends program
        if (zcnt == 4'h0) begin
          n.run = 1'b0;
          n.state = ST_IDLE;
        end else begin
          // RULE_11 pointer used when count nonzero
          n.cur = {r.desc[2][31:4], 4'h0};
          n.remain = zcnt;
          n.first = 1'b1;
          n.state = ST_FETCH;
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase

    // RULE_12 resume at recovery pointer
    if (r.active && restart_ev && r.recov_ok && r.state != ST_IDLE) begin
      n.cur = {r.recov, 4'h0};
      n.remain = r.recov_cnt;
      n.first = 1'b1;
      n.widx = 2'h0;
      n.mreq = 1'b0;
      n.mwe = 1'b0;
      n.txv = 1'b0;
      n.txl = 1'b0;
      n.evcode = EVT_RECOVER;
      n.state = (r.recov_cnt == 4'h0) ? ST_IDLE : ST_FETCH;
    end

    // Software stop drops any memory request, not a pending transmit word
    if (!n.run && r.state != ST_IDLE) begin
      n.mreq = 1'b0;
      n.mwe = 1'b0;
      n.state = ST_IDLE;
    end

    // Address phase, read data taken after this cycle's updates
    if (HSEL && HTRANS[1] && HREADY) begin
      n.ahb_wr = HWRITE;
      n.ahb_ofs = HADDR[7:0];
      case (HADDR[7:0])
        OFF_CTRL: n.rdata = ctrl_word(n);
        OFF_PROG: n.rdata = {n.prog_addr, n.prog_cnt};
        OFF_EVENT: n.rdata = {31'h0000_0000, n.evt};
        OFF_MASK: n.rdata = {31'h0000_0000, n.mask};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign HRDATA = r.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign MEM_REQ = r.mreq;
  assign MEM_WRITE = r.mwe;
  assign MEM_ADDR = r.maddr;
  assign MEM_WDATA = r.mwdata;
  assign TXB_VALID = r.txv;
  assign TXB_DATA = r.txd;
  assign TXB_LAST = r.txl;
  // RULE_20 masked host interrupt
  assign IRQ = r.evt & r.mask;

endmodule

/* testbench/itd_monitor.sv */
`timescale 1ns/1ns
module itd_monitor (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic MEM_REQ,
  input wire logic MEM_WRITE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic TXB_VALID,
  input wire logic [31:0] TXB_DATA,
  input wire logic TXB_LAST,
  input wire logic TXB_READY
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  sequence req_wait; MEM_REQ && !MEM_ACK; endsequence
  sequence req_held; MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WDATA) && $stable(MEM_WRITE); endsequence
  sequence tx_wait; TXB_VALID && !TXB_READY; endsequence
  sequence tx_held; TXB_VALID && $stable(TXB_DATA) && $stable(TXB_LAST); endsequence
  mem_req_hold_a: assert property (req_wait |=> req_held) else $error("request moved");
  mem_ack_drop_a: assert property (MEM_ACK |=> !MEM_REQ) else $error("request kept");
  tx_word_hold_a: assert property (tx_wait |=> tx_held) else $error("word moved");
  tx_word_gap_a: assert property (TXB_VALID && TXB_READY |=> !TXB_VALID) else $error("no gap");
  tx_after_ack_a: assert property ($rose(TXB_VALID) |-> $past(MEM_ACK)) else $error("word w/o ack");
  store_pad_a: assert property (MEM_REQ && MEM_WRITE && MEM_ADDR[3:0] != 4'h0C |-> MEM_WDATA[31:16] == 16'h0000)
    else $error("store not padded");
  rdata_hold_a: assert property (!(HSEL && HTRANS[1]) |=> $stable(HRDATA)) else $error("rdata moved");
  bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus not okay");
endmodule
bind itd_engine itd_monitor mon_u (.MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE),
  .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .TXB_VALID(TXB_VALID),
  .TXB_DATA(TXB_DATA), .TXB_LAST(TXB_LAST), .TXB_READY(TXB_READY));

/* testbench/itd_mem.sv */
`timescale 1ns/1ns
module itd_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic req,
  input wire logic write,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:4095];
  logic [1:0] cnt_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      cnt_r <= 2'h0;
      rdata <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      ack <= 1'b0;
      // Stale data is inverted once the answer is gone
      rdata <= ~rdata;
      if (req && !ack && (!slow || cnt_r == 2'h0)) begin
        ack <= 1'b1;
        if (write)
          mem[addr[13:2]] <= wdata;
        else
          rdata <= mem[addr[13:2]];
      end
    end
  end
endmodule

/* testbench/iso_transmit_descriptor_dma_tb.sv */
`timescale 1ns/1ns
module iso_transmit_descriptor_dma_tb;
  import itd_pkg::*;
  logic MCLK = 0, RESETN = 0, HSEL = 0, HWRITE = 0, TXB_READY = 0, BUS_RESET = 0, CYCLE_LOST = 0, slow = 0;
  logic HREADYOUT, HRESP, MEM_REQ, MEM_WRITE, MEM_ACK, TXB_VALID, TXB_LAST, IRQ;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, TXB_DATA, rd, base, hw, h0, h1;
  logic [1:0] HTRANS = 0, isel;
  logic [2:0] HSIZE = 3'h2;
  logic [12:0] CYCLE_NUMBER = 0;
  logic [6:0] SECONDS_COUNT = 0;
  logic [6:0] bad [4] = '{7'h16, 7'h01, 7'h20, 7'h07};
  logic [32:0] got [$];
  int errors = 0, n_tests = 0, seed = 32'hbdce, n;
  itd_engine dut_u (.MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA), .TXB_VALID(TXB_VALID), .TXB_DATA(TXB_DATA), .TXB_LAST(TXB_LAST), .TXB_READY(TXB_READY),
    .BUS_RESET(BUS_RESET), .CYCLE_LOST(CYCLE_LOST), .CYCLE_NUMBER(CYCLE_NUMBER), .SECONDS_COUNT(SECONDS_COUNT),
    .IRQ(IRQ));
  itd_mem mem_u (.clk(MCLK), .rst_n(RESETN), .slow(slow), .req(MEM_REQ), .write(MEM_WRITE), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
  initial forever #50 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    if (TXB_VALID && TXB_READY)
      got.push_back({TXB_LAST, TXB_DATA});
    TXB_READY <= ($random(seed) & 3) != 0;
  end
  task summarize;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [32:0] g, input logic [32:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge MCLK);
    HSEL <= 1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= w;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    HSEL <= 0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    rd = HRDATA;
  endtask
  task put(input logic [31:0] a, input logic [31:0] d);
    mem_u.mem[a[13:2]] = d;
  endtask
  function automatic logic [31:0] w0(logic [3:0] o, logic wb, logic [2:0] v, logic [1:0] i, logic [15:0] c);
    return {o, wb, v, 2'b00, i, 2'b11, 2'b00, c};
  endfunction
  function automatic logic [31:0] wb_word(input logic [4:0] e);
    logic [15:0] s;
    s = 16'h0000;
    s[CTL_RUN_BIT] = 1'b1;
    s[CTL_ACTIVE_BIT] = 1'b1;
    s[4:0] = e;
    return {s, SECONDS_COUNT[2:0], CYCLE_NUMBER};
  endfunction
  task run(input logic [31:0] b, input logic [3:0] c);
    got.delete();
    ahb(1, OFF_PROG, {b[31:4], c});
    ahb(1, OFF_CTRL, 32'h0000_8000);
    // Poll until idle; a hang is left to the watchdog
    do begin
      ahb(0, OFF_CTRL, 0);
    end while (!(rd[10] === 1'b0 && (rd[15] === 1'b0 || rd[11] === 1'b1)));
  endtask
  initial begin
    repeat (12) @(posedge MCLK);
    RESETN <= 1;
    ahb(0, 32'h0000_0010, 0);
    chk(rd, 0);
    for (int k = 0; k < 4; k++) begin
      base = 32'h0000_1000;
      n = 1 + ($random(seed) & 15);
      isel = k[0] ? 2'h0 : ISEL_EVT;
      slow <= k[1];
      hw = $random(seed);
      h0 = $random(seed);
      h1 = $random(seed);
      CYCLE_NUMBER <= 13'($random(seed));
      SECONDS_COUNT <= 7'($random(seed));
      put(base, w0(OPC_CONT, 0, VAR_INLINE, 0, 16'h0008));
      put(base + 16, h0);
      put(base + 20, h1);
      put(base + 32, w0(OPC_CONT, 0, VAR_STORE, 0, hw[15:0]));
      put(base + 36, 32'h0000_3000);
      put(base + 48, w0(OPC_FINAL, k < 2, VAR_BUF, isel, 16'(4 * n)));
      put(base + 52, 32'h0000_2000);
      put(base + 56, 0);
      put(base + 60, 32'hdead_beef);
      put(32'h0000_3000, 32'hffff_ffff);
      for (int i = 0; i < n; i++) put(32'h0000_2000 + 4 * i, $random(seed));
      ahb(1, OFF_EVENT, 1);
      ahb(1, OFF_MASK, k[1]);
      run(base, 4'h4);
      chk(got.size(), n + 2);
      chk(got[0], {1'b0, h0});
      chk(got[1], {1'b0, h1});
      for (int i = 0; i < n; i++) chk(got[i + 2], {i == n - 1, mem_u.mem[12'h800 + i]});
      chk(mem_u.mem[12'hC00], {16'h0000, hw[15:0]});
      chk(mem_u.mem[12'h40F], k < 2 ? wb_word(EVT_DONE) : 32'hdead_beef);
      ahb(0, OFF_EVENT, 0);
      chk(rd[0], isel == ISEL_EVT);
      chk(IRQ, isel == ISEL_EVT && k[1]);
      ahb(0, OFF_CTRL, 0);
      chk({rd[15], rd[11], rd[10], rd[4:0]}, {3'b000, EVT_DONE});
      ahb(1, OFF_EVENT, 1);
      ahb(0, OFF_EVENT, 0);
      chk(rd[0], 0);
      $display("transmit test %0d done", k);
    end
    put(32'h0000_1800, w0(OPC_FINAL, 0, VAR_BUF, ISEL_EVT, 16'h0000));
    // Next block of one, itself a zero-count final with writeback
    put(32'h0000_1808, 32'h0000_1841);
    put(32'h0000_1840, w0(OPC_FINAL, 1, VAR_BUF, 0, 16'h0000));
    put(32'h0000_1848, 0);
    run(32'h0000_1800, 4'h1);
    chk(got.size(), 0);
    chk({rd[15], rd[10], rd[4:0]}, {2'b00, EVT_SKIPPED});
    chk(mem_u.mem[12'h613], wb_word(EVT_SKIPPED));
    $display("skip test done");
    for (int k = 0; k < 4; k++) begin
      put(32'h0000_1C00, w0(bad[k][6:3], 0, bad[k][2:0], 0, 16'h0008));
      run(32'h0000_1C00, 4'h2);
      chk({got.size() == 0, rd[11], rd[10]}, 3'b110);
      ahb(1, OFF_CTRL, 0);
      ahb(0, OFF_CTRL, 0);
      chk(rd[11], 0);
    end
    $display("invalid test done");
    summarize;
  end
  initial begin
    #(100 * 60000);
    errors++;
    summarize;
  end
endmodule
